// file: logic/pcxpm_master.sv
// two-port serial polling master for particle counters
// assumes host words arrive with valid/ready on clk_sys; run level and rxd are async pins
`timescale 1ns/1ps
// Notes on behaviour
// - select code is address 0..31 plus 128
// - blocks hold at most 64 words
// - outside run, stop blocks and serial traffic
// - repoll while counter answers '#', then extract
// - operating mode returned in read block
// - communication error codes returned in read block
// - blocks taken and returned as whole units
// - two independent serial ports, each polling
// - baud code 0..7 selects 300..38400
// - first word: 0 port1, 1 port2, 255 config
// - report 255 and idle until configured
// - high byte 1 enables, low byte addresses
module pcxpm_master
  import pcxpm_pkg::*;
#(
  parameter logic [TMR_W-1:0] RTS_CYCLES = RTS_CYC,
  parameter logic [TMR_W-1:0] TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter logic [TMR_W-1:0] POLL_CYCLES = POLL_CYC
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic host_in_run,
  input wire logic host_block_write_valid,
  output logic host_block_write_ready,
  input wire logic [WORD_W-1:0] host_block_write_data,
  output logic host_block_read_valid,
  input wire logic host_block_read_ready,
  output logic [WORD_W-1:0] host_block_read_data,
  input wire logic [1:0] ser_rxd,
  output logic [1:0] ser_txd,
  output logic [1:0] ser_rts
);
  logic [2:0] run_s;
  logic run_lv;
  logic comm_hold;
  logic [5:0] wr_idx;
  logic [7:0] wr_id;
  logic cfg_ok;
  logic cfg_err;
  logic cfg_pulse;
  logic [7:0] last_wid;
  logic [2:0] cfg_baud [2];
  logic [5:0] cfg_nslv [2];
  logic [2:0] stg_baud [2];
  logic [5:0] stg_nslv [2];
  logic stg_en [SLOTS];
  logic [4:0] stg_addr [SLOTS];
  logic slot_en [2][SLOTS];
  logic [4:0] slot_addr [2][SLOTS];
  logic [5:0] rd_idx;
  logic rd_port;
  logic [WORD_W-1:0] snap_mode;
  logic [WORD_W-1:0] snap_err;
  logic [WORD_W-1:0] snap_addr;
  logic [WORD_W-1:0] snap_data;
  logic [WORD_W-1:0] snap_wid;
  logic [15:0] port_err [2];
  logic [4:0] port_addr [2];
  logic [15:0] port_data [2];

  // host write decode
  logic take;
  logic blk_done;
  logic in_slots;
  logic [4:0] stg_slot;
  logic ctrl_on;
  logic addr_ok;
  logic mix_rate;
  logic next_cfg_err;
  logic go;
  assign take = host_block_write_valid && host_block_write_ready;
  assign blk_done = take && (wr_idx == BLK_LAST);
  assign in_slots = (wr_idx != 6'h00) && (wr_idx <= 6'(SLOTS));
  assign stg_slot = 5'(wr_idx - 6'h01);
  assign ctrl_on = host_block_write_data[15:8] == POLL_ON;
  assign addr_ok = host_block_write_data[7:0] <= MAX_ADDR;
  // 19200 and 38400 cannot share the module
  assign mix_rate = ({stg_baud[0], stg_baud[1]} == {BAUD_19200, BAUD_38400})
                 || ({stg_baud[0], stg_baud[1]} == {BAUD_38400, BAUD_19200});
  assign next_cfg_err = mix_rate || (stg_nslv[0] > MAX_SLAVES) || (stg_nslv[1] > MAX_SLAVES);
  assign go = cfg_ok && !cfg_err && !comm_hold && !cfg_pulse;

  // run pin: three flops, change counts once second and third agree
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      run_s <= 3'h0;
      run_lv <= 1'b0;
    end
    else
    begin
      run_s <= {run_s[1:0], host_in_run};
      if (run_s[1] == run_s[2])
        run_lv <= run_s[2];
    end
  end

  // hold is set by leaving run, released by the next complete write block
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      comm_hold <= 1'b0;
      host_block_write_ready <= 1'b0;
    end
    else
    begin
      host_block_write_ready <= run_lv;
      if (!run_lv)
        comm_hold <= 1'b1;
      else if (blk_done)
        comm_hold <= 1'b0;
    end
  end

  // staging: words land here, tables change only at the block's last word
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_idx <= 6'h00;
      wr_id <= 8'h00;
      stg_baud <= '{default: 3'h0};
      stg_nslv <= '{default: 6'h00};
      stg_en <= '{default: 1'b0};
      stg_addr <= '{default: 5'h00};
    end
    else if (!host_block_write_ready)
      wr_idx <= 6'h00; // a partly written block is dropped
    else if (take)
    begin
      wr_idx <= wr_idx + 6'h01;
      if (wr_idx == 6'h00)
        wr_id <= host_block_write_data[7:0];
      if (in_slots)
      begin
        stg_en[stg_slot] <= ctrl_on && addr_ok;
        stg_addr[stg_slot] <= host_block_write_data[4:0];
      end
      for (int p = 0; p < 2; p++)
      begin
        if (wr_idx == 6'(CFG_BAUD_POS + p * CFG_STRIDE))
          stg_baud[p] <= host_block_write_data[2:0];
        if (wr_idx == 6'(CFG_NSLV_POS + p * CFG_STRIDE))
          stg_nslv[p] <= host_block_write_data[5:0];
      end
    end
  end

  // commit of a finished block by its identifier
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_ok <= 1'b0;
      cfg_err <= 1'b0;
      cfg_pulse <= 1'b0;
      last_wid <= ID_CONFIG;
      cfg_baud <= '{default: 3'h0};
      cfg_nslv <= '{default: 6'h00};
      slot_en <= '{default: '{default: 1'b0}};
      slot_addr <= '{default: '{default: 5'h00}};
    end
    else
    begin
      cfg_pulse <= blk_done && (wr_id == ID_CONFIG);
      if (blk_done)
      begin
        last_wid <= wr_id;
        if (wr_id == ID_CONFIG)
        begin
          cfg_ok <= 1'b1;
          cfg_err <= next_cfg_err;
          cfg_baud <= stg_baud;
          cfg_nslv <= stg_nslv;
        end
        else if (wr_id == ID_PORT1 || wr_id == ID_PORT2)
        begin
          slot_en[wr_id[0]] <= stg_en;
          slot_addr[wr_id[0]] <= stg_addr;
        end
      end
    end
  end

  // one polling engine and uart per port
  for (genvar g = 0; g < 2; g++)
  begin : g_port
    pcxpm_state_t st;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] ptmr;
    logic poll_tick;
    logic [5:0] slot;
    logic [1:0] bidx;
    logic rxn;
    logic [7:0] b0;
    logic tx_load;
    logic [7:0] tx_byte;
    logic [8:0] tx_sh;
    logic [3:0] tx_left;
    logic [DIV_W-1:0] tx_cnt;
    logic txd;
    logic rts;
    logic [2:0] rx_s;
    logic rx_lv;
    logic rx_busy;
    logic [3:0] rx_left;
    logic [DIV_W-1:0] rx_cnt;
    logic [7:0] rx_sh;
    logic rx_done;
    logic rx_ferr;
    logic [DIV_W-1:0] div;
    logic tx_busy;
    logic [4:0] cur_addr;
    logic end_of_list;
    assign div = pcxpm_baud_div(cfg_baud[g]);
    assign tx_busy = tx_left != 4'h0;
    assign cur_addr = slot_addr[g][slot[4:0]];
    assign end_of_list = (slot >= cfg_nslv[g]) || (slot >= MAX_SLAVES);
    assign poll_tick = ptmr == POLL_CYCLES - 1'b1;
    assign ser_txd[g] = txd;
    assign ser_rts[g] = rts;

    // 8n1 transmitter, stop bit from the high ninth bit loaded above the byte
    always_ff @(posedge clk_sys or negedge rstn)
    begin
      if (!rstn)
      begin
        tx_sh <= 9'h1ff;
        tx_left <= 4'h0;
        tx_cnt <= '0;
        txd <= 1'b1;
      end
      else if (tx_load)
      begin
        tx_sh <= {1'b1, tx_byte};
        tx_left <= 4'ha;
        tx_cnt <= '0;
        txd <= 1'b0;
      end
      else if (tx_busy && tx_cnt == div - 1'b1)
      begin
        tx_cnt <= '0;
        tx_left <= tx_left - 4'h1;
        txd <= tx_sh[0];
        tx_sh <= {1'b1, tx_sh[8:1]};
      end
      else if (tx_busy)
        tx_cnt <= tx_cnt + 1'b1;
    end

    // receiver: three-flop pin sync, mid-bit sampling, framing check
    always_ff @(posedge clk_sys or negedge rstn)
    begin
      if (!rstn)
      begin
        rx_s <= 3'h7;
        rx_lv <= 1'b1;
        rx_busy <= 1'b0;
        rx_left <= 4'h0;
        rx_cnt <= '0;
        rx_sh <= 8'h00;
        rx_done <= 1'b0;
        rx_ferr <= 1'b0;
      end
      else
      begin
        rx_s <= {rx_s[1:0], ser_rxd[g]};
        if (rx_s[1] == rx_s[2])
          rx_lv <= rx_s[2];
        rx_done <= 1'b0;
        rx_ferr <= 1'b0;
        if (!rx_busy && !rx_lv)
        begin
          rx_busy <= 1'b1;
          rx_left <= 4'ha;
          rx_cnt <= div >> 1;
        end
        else if (rx_busy && rx_cnt != '0)
          rx_cnt <= rx_cnt - 1'b1;
        else if (rx_busy)
        begin
          rx_cnt <= div - 1'b1;
          rx_left <= rx_left - 4'h1;
          if (rx_left == 4'ha && rx_lv)
            rx_busy <= 1'b0; // glitch, not a start bit
          else if (rx_left == 4'h1)
          begin
            rx_busy <= 1'b0;
            rx_done <= rx_lv;
            rx_ferr <= !rx_lv;
          end
          else if (rx_left != 4'ha)
            rx_sh <= {rx_lv, rx_sh[7:1]};
        end
      end
    end

    // poll period timer, one sweep of the list per tick
    always_ff @(posedge clk_sys or negedge rstn)
    begin
      if (!rstn)
        ptmr <= '0;
      else if (!go || poll_tick)
        ptmr <= '0;
      else
        ptmr <= ptmr + 1'b1;
    end

    // polling engine; held idle until configured and while in hold
    always_ff @(posedge clk_sys or negedge rstn)
    begin
      if (!rstn)
      begin
        st <= ST_IDLE;
        tmr <= '0;
        slot <= 6'h00;
        bidx <= 2'h0;
        rxn <= 1'b0;
        b0 <= 8'h00;
        tx_load <= 1'b0;
        tx_byte <= 8'h00;
        rts <= 1'b0;
        port_err[g] <= ERR_NONE;
        port_addr[g] <= 5'h00;
        port_data[g] <= 16'h0000;
      end
      else if (!go)
      begin
        st <= ST_IDLE;
        rts <= rts && (tx_busy || tx_load); // let a byte on the wire finish, never cut the driver mid-byte
        tx_load <= 1'b0;
        if (cfg_pulse)
          port_err[g] <= ERR_NONE;
      end
      else
      begin
        tx_load <= 1'b0;
        unique case (st)
          ST_IDLE:
          begin
            slot <= 6'h00;
            if (poll_tick)
              st <= ST_SCAN;
          end
          ST_SCAN:
          begin
            tmr <= '0;
            bidx <= 2'h0;
            if (end_of_list)
              st <= ST_IDLE;
            else if (slot_en[g][slot[4:0]])
            begin
              st <= ST_RTS;
              rts <= 1'b1;
            end
            else
              slot <= slot + 6'h01;
          end
          ST_RTS:
          begin
            tmr <= tmr + 1'b1;
            if (tmr == RTS_CYCLES - 1'b1)
              st <= ST_TX;
          end
          ST_TX:
            if (!tx_busy && !tx_load && bidx == 2'h2)
            begin
              st <= ST_RX;
              rts <= 1'b0;
              tmr <= '0;
              rxn <= 1'b0;
            end
            else if (!tx_busy && !tx_load)
            begin
              tx_load <= 1'b1;
              tx_byte <= (bidx == 2'h0) ? (SEL_BASE + {3'h0, cur_addr}) : CMD_SEND;
              bidx <= bidx + 2'h1;
            end
          ST_RX:
          begin
            tmr <= tmr + 1'b1;
            if (rx_done && !rxn && rx_sh == CH_WAIT)
            begin
              st <= ST_RTS; // not ready yet: poll again
              rts <= 1'b1;
              tmr <= '0;
              bidx <= 2'h0;
            end
            else if (rx_done && !rxn)
            begin
              b0 <= rx_sh;
              rxn <= 1'b1;
            end
            else if (rx_done)
            begin
              port_data[g] <= {b0, rx_sh};
              port_addr[g] <= cur_addr;
              slot <= slot + 6'h01;
              st <= ST_SCAN;
            end
            else if (rx_ferr || tmr == TIMEOUT_CYCLES - 1'b1)
            begin
              port_err[g] <= rx_ferr ? ERR_FRAME : ERR_TIMEOUT;
              slot <= slot + 6'h01;
              st <= ST_SCAN;
            end
          end
        endcase
      end
    end
  end

  // read side: blocks alternate between ports, fields frozen at word 0
  logic rd_ready;
  logic rd_push;
  logic [WORD_W-1:0] cur_mode;
  logic [WORD_W-1:0] cur_err;
  logic [WORD_W-1:0] rd_word;
  assign rd_push = run_lv && rd_ready;
  assign cur_mode = cfg_err ? MODE_CFG_ERR : (comm_hold ? MODE_HALT : MODE_RUN);
  assign cur_err = cfg_err ? ERR_CFG : port_err[rd_port];
  assign rd_word = (rd_idx == RD_ID) ? {15'h0000, rd_port}
                 : (rd_idx == RD_WID) ? snap_wid
                 : (rd_idx == RD_MODE) ? snap_mode
                 : (rd_idx == RD_ERR) ? snap_err
                 : (rd_idx == RD_ADDR) ? snap_addr
                 : (rd_idx == RD_DATA) ? snap_data
                 : 16'h0000;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_idx <= 6'h00;
      rd_port <= 1'b0;
      snap_wid <= UNCONF_WORD;
      snap_mode <= 16'h0000;
      snap_err <= ERR_NONE;
      snap_addr <= 16'h0000;
      snap_data <= 16'h0000;
    end
    else if (rd_push)
    begin
      rd_idx <= rd_idx + 6'h01;
      if (rd_idx == BLK_LAST)
        rd_port <= !rd_port;
      if (rd_idx == RD_ID)
      begin
        snap_wid <= cfg_ok ? {8'h00, last_wid} : UNCONF_WORD;
        snap_mode <= cur_mode;
        snap_err <= cur_err;
        snap_addr <= {11'h000, port_addr[rd_port]};
        snap_data <= port_data[rd_port];
      end
    end
  end

  // host stall backs up here without losing a word
  pcxpm_buf2 #(.W(WORD_W)) u_rd_buf (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(rd_push),
    .in_ready(rd_ready),
    .in_data(rd_word),
    .out_valid(host_block_read_valid),
    .out_ready(host_block_read_ready),
    .out_data(host_block_read_data)
  );
endmodule

// file: logic/pcxpm_pkg.sv
// constants, codes and helpers shared by the polling master and its buffer
// assumes one 100 MHz system clock; no timescale in a package
package pcxpm_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int WORD_W = 16;
  localparam int BLK_WORDS = 64;
  localparam logic [5:0] BLK_LAST = 6'h3f;
  localparam int SLOTS = 32;
  localparam logic [7:0] MAX_ADDR = 8'h1f;
  localparam logic [5:0] MAX_SLAVES = 6'h20;
  // incoming block identifiers
  localparam logic [7:0] ID_PORT1 = 8'h00;
  localparam logic [7:0] ID_PORT2 = 8'h01;
  localparam logic [7:0] ID_CONFIG = 8'hff;
  localparam logic [15:0] UNCONF_WORD = 16'h00ff;
  // config block layout: baud at 1+10*p, slave count at 2+10*p
  localparam int CFG_BAUD_POS = 1;
  localparam int CFG_NSLV_POS = 2;
  localparam int CFG_STRIDE = 10;
  localparam logic [7:0] POLL_ON = 8'h01;
  // returned block layout
  localparam logic [5:0] RD_ID = 6'h00;
  localparam logic [5:0] RD_WID = 6'h01;
  localparam logic [5:0] RD_MODE = 6'h02;
  localparam logic [5:0] RD_ERR = 6'h03;
  localparam logic [5:0] RD_ADDR = 6'h04;
  localparam logic [5:0] RD_DATA = 6'h05;
  // operating modes and error codes
  localparam logic [15:0] MODE_RUN = 16'h0001;
  localparam logic [15:0] MODE_HALT = 16'h0002;
  localparam logic [15:0] MODE_CFG_ERR = 16'h0003;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_TIMEOUT = 16'h0001;
  localparam logic [15:0] ERR_CFG = 16'h0002;
  localparam logic [15:0] ERR_FRAME = 16'h0003;
  // counter protocol bytes
  localparam logic [7:0] SEL_BASE = 8'h80;
  localparam logic [7:0] CMD_SEND = 8'h41;
  localparam logic [7:0] CH_WAIT = 8'h23;
  // baud codes 0..7 give 300 << code
  localparam int BAUD_BASE = 300;
  localparam logic [2:0] BAUD_19200 = 3'h6;
  localparam logic [2:0] BAUD_38400 = 3'h7;
  localparam int DIV_W = 19;
  // serial timing
  localparam int RTS_MS = 50;
  localparam int TIMEOUT_MS = 1000;
  localparam int POLL_MS = 1000;
  localparam int TMR_W = 27;
  localparam logic [TMR_W-1:0] RTS_CYC = TMR_W'(CLK_HZ / 1000 * RTS_MS);
  localparam logic [TMR_W-1:0] TIMEOUT_CYC = TMR_W'(CLK_HZ / 1000 * TIMEOUT_MS);
  localparam logic [TMR_W-1:0] POLL_CYC = TMR_W'(CLK_HZ / 1000 * POLL_MS);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SCAN = 3'b001,
    ST_RTS = 3'b010,
    ST_TX = 3'b011,
    ST_RX = 3'b100
  } pcxpm_state_t;

  // clock cycles per bit for a baud code
  function automatic logic [DIV_W-1:0] pcxpm_baud_div(input logic [2:0] code);
    pcxpm_baud_div = DIV_W'(CLK_HZ / (BAUD_BASE << code));
  endfunction
endpackage

// file: logic/pcxpm_buf2.sv
// two-entry buffer with valid/ready on both sides
// assumes single clock; out_valid and out_data come straight from flops, in_ready is the inverse of v1
`timescale 1ns/1ps
module pcxpm_buf2
  import pcxpm_pkg::*;
#(
  parameter int W = WORD_W
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] d1;
  logic v1;
  logic push;
  logic pop;
  logic next_v0;

  // ready is the inverse of the second slot, so a stall never drops a word
  assign in_ready = !v1;
  assign push = in_valid && !v1;
  assign pop = out_valid && out_ready;
  assign next_v0 = pop ? v1 : out_valid;

  // head shifts forward on pop, new word lands in first free slot
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      out_valid <= 1'b0;
      v1 <= 1'b0;
      out_data <= '0;
      d1 <= '0;
    end
    else
    begin
      if (pop)
      begin
        out_data <= d1;
        out_valid <= v1;
        v1 <= 1'b0;
      end
      if (push && !next_v0)
      begin
        out_data <= in_data;
        out_valid <= 1'b1;
      end
      else if (push)
      begin
        d1 <= in_data;
        v1 <= 1'b1;
      end
    end
  end
endmodule

// file: test/pcxpm_master_assertions.sv
// port-level assertions for the polling master
// assumes one clock, active-low async reset, bound from the bench
`timescale 1ns/1ps
module pcxpm_master_chk
  import pcxpm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic host_in_run,
  input wire logic host_block_write_ready,
  input wire logic host_block_read_valid,
  input wire logic host_block_read_ready,
  input wire logic [WORD_W-1:0] host_block_read_data,
  input wire logic [1:0] ser_txd,
  input wire logic [1:0] ser_rts
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // eight samples at one level outlast the run synchroniser
  chk_wr_refused: assert property (!host_in_run [*8] |-> !host_block_write_ready)
    else $error("write ready high outside run");
  chk_wr_resumed: assert property (host_in_run [*8] |-> host_block_write_ready)
    else $error("write ready low in run");
  chk_no_new_poll: assert property (!host_in_run [*8] |-> !$rose(ser_rts[0]) && !$rose(ser_rts[1]))
    else $error("poll started outside run");
  // line idles high whenever the driver is off
  chk_idle_port0: assert property (!ser_rts[0] |-> ser_txd[0])
    else $error("port 0 txd low with rts off");
  chk_idle_port1: assert property (!ser_rts[1] |-> ser_txd[1])
    else $error("port 1 txd low with rts off");
  chk_rts_lead: assert property ($rose(ser_rts[0]) |-> ser_txd[0] [*8])
    else $error("start bit inside rts lead");
  chk_start_rts: assert property ($fell(ser_txd[1]) |-> ser_rts[1])
    else $error("port 1 sends without rts");
  // a stalled read word must not change under the host
  chk_read_hold: assert property (host_block_read_valid && !host_block_read_ready |=>
    host_block_read_valid && $stable(host_block_read_data))
    else $error("read word changed before taken");
  cov_poll: cover property ($rose(ser_rts[0]));
  cov_stall: cover property (host_block_read_valid && !host_block_read_ready);
  cov_run_drop: cover property ($fell(host_block_write_ready));
endmodule

// file: test/pcxpm_counter_model.sv
// behavioural particle counter on one serial port
// assumes 8N1 at BIT clocks per bit; answers every send-record with the wait mark
`timescale 1ns/1ps
module pcxpm_counter_model
  import pcxpm_pkg::*;
#(
  parameter int BIT = 2604,
  parameter int GAP = 100
)
(
  input wire logic clk_sys,
  input wire logic txd,
  output logic rxd,
  output logic [7:0] last_byte,
  output logic [7:0] byte_cnt
);
  logic [7:0] sh;
  // start bit, eight data bits lsb first, one stop bit, no parity
  task automatic get_byte();
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge clk_sys);
      sh[i] = txd;
    end
    repeat (BIT) @(posedge clk_sys);
    last_byte = sh;
    byte_cnt = byte_cnt + 8'h01;
  endtask
  // reply bits change on the falling edge, away from the master's sampling edge
  task automatic put_byte(input logic [7:0] b);
    rxd = 1'b0;
    repeat (BIT) @(negedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      rxd = b[i];
      repeat (BIT) @(negedge clk_sys);
    end
    rxd = 1'b1;
    repeat (BIT) @(negedge clk_sys);
  endtask
  // line biased high when idle; reply only after a send-record
  initial
  begin
    rxd = 1'b1;
    last_byte = 8'h00;
    byte_cnt = 8'h00;
    forever
    begin
      get_byte();
      if (last_byte == CMD_SEND)
      begin
        repeat (GAP) @(negedge clk_sys);
        put_byte(CH_WAIT);
      end
    end
  end
endmodule

// file: test/pcxpm_master_tb.sv
// bench for the polling master: host block tasks plus one counter model
// assumes short lead and poll counts; baud code 7 on the polled port
`timescale 1ns/1ps
module pcxpm_master_tb
  import pcxpm_pkg::*;
;
  logic clk_sys, rstn, host_in_run, host_block_write_valid, host_block_write_ready;
  logic host_block_read_valid, host_block_read_ready, m_rxd, rd_port;
  logic [15:0] host_block_write_data, host_block_read_data;
  logic [1:0] ser_rxd, ser_txd, ser_rts;
  logic [7:0] m_last, m_cnt;
  logic [15:0] wr_words [64];
  logic [15:0] rd_words [64];
  int err_count = 0;
  int total_checks = 0;
  // second port has no counters, its line rests high
  assign ser_rxd = {1'b1, m_rxd};
  // lead must outlast the counter's stop bit, or the repoll collides with the reply
  pcxpm_master #(.RTS_CYCLES(TMR_W'(2000)), .TIMEOUT_CYCLES(TMR_W'(60000)), .POLL_CYCLES(TMR_W'(3000)))
  pcxpm_master_inst (.clk_sys(clk_sys), .rstn(rstn), .host_in_run(host_in_run),
    .host_block_write_valid(host_block_write_valid), .host_block_write_ready(host_block_write_ready),
    .host_block_write_data(host_block_write_data), .host_block_read_valid(host_block_read_valid),
    .host_block_read_ready(host_block_read_ready), .host_block_read_data(host_block_read_data),
    .ser_rxd(ser_rxd), .ser_txd(ser_txd), .ser_rts(ser_rts));
  pcxpm_counter_model #(.BIT(2604), .GAP(100)) pcxpm_counter_model_inst (.clk_sys(clk_sys),
    .txd(ser_txd[0]), .rxd(m_rxd), .last_byte(m_last), .byte_cnt(m_cnt));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // words held until the edge that takes them
  task automatic write_block(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk_sys);
      host_block_write_valid = 1'b1;
      host_block_write_data = wr_words[i];
      @(posedge clk_sys);
      while (host_block_write_ready !== 1'b1)
        @(posedge clk_sys);
    end
    @(negedge clk_sys);
    host_block_write_valid = 1'b0;
  endtask
  // a word seen valid at a falling edge leaves at the next rising edge
  task automatic read_block();
    int i;
    i = 0;
    @(negedge clk_sys);
    host_block_read_ready = 1'b1;
    while (i < 64)
    begin
      if (host_block_read_valid === 1'b1)
      begin
        rd_words[i] = host_block_read_data;
        i++;
      end
      @(negedge clk_sys);
    end
    host_block_read_ready = 1'b0;
    check16(rd_words[0], {15'h0000, rd_port}, "port id");
    rd_port = ~rd_port;
  endtask
  // the block already begun was frozen before the last write; read two and keep the third
  task automatic read_fresh();
    repeat (3) read_block();
  endtask
  task automatic send_cfg(input logic [2:0] b1, input logic [2:0] b2, input logic [7:0] n1);
    wr_words = '{default: 16'h0000};
    wr_words[0] = {8'h00, ID_CONFIG};
    wr_words[1] = {13'h0000, b1};
    wr_words[2] = {8'h00, n1};
    wr_words[11] = {13'h0000, b2};
    write_block(64);
  endtask
  // hang guard
  initial
  begin
    repeat (160000) @(posedge clk_sys);
    err_count++;
    $display("mismatch at %0t: run too long", $time);
    wrap_up();
  end
  initial
  begin
    rstn = 1'b0;
    host_in_run = 1'b1;
    host_block_write_valid = 1'b0;
    host_block_write_data = 16'h0000;
    host_block_read_ready = 1'b0;
    rd_port = 1'b0;
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    read_block();
    check16(rd_words[1], UNCONF_WORD, "unconfigured marker");
    check16(rd_words[2], MODE_HALT, "held until first block");
    repeat (4000) @(negedge clk_sys);
    check16({8'h00, m_cnt}, 16'h0000, "no poll before config");
    // every baud code accepted when both ports agree
    for (int c = 0; c < 8; c++)
    begin
      send_cfg(3'(c), 3'(c), 8'h00);
      read_fresh();
      check16(rd_words[2], MODE_RUN, "mode per baud code");
    end
    check16(rd_words[1], {8'h00, ID_CONFIG}, "last write id");
    send_cfg(BAUD_38400, BAUD_38400, 8'h01);
    wr_words = '{default: 16'h0000};
    wr_words[1] = {POLL_ON, 8'h05};
    write_block(64);
    read_fresh();
    check16(rd_words[1], {8'h00, ID_PORT1}, "control id echoed");
    check16(rd_words[3], ERR_NONE, "no error");
    wait (m_cnt == 8'h01);
    check16({8'h00, m_last}, {8'h00, SEL_BASE + 8'h05}, "select code");
    wait (m_cnt == 8'h02);
    check16({8'h00, m_last}, {8'h00, CMD_SEND}, "send record");
    wait (m_cnt == 8'h03);
    check16({8'h00, m_last}, {8'h00, SEL_BASE + 8'h05}, "repoll after wait mark");
    send_cfg(BAUD_19200, BAUD_38400, 8'h01);
    read_fresh();
    check16(rd_words[2], MODE_CFG_ERR, "mixed baud mode");
    check16(rd_words[3], ERR_CFG, "mixed baud error");
    // leave run in mid-block, then come back
    wr_words = '{default: 16'h0000};
    wr_words[0] = {8'h00, ID_PORT2};
    write_block(10);
    host_in_run = 1'b0;
    repeat (20) @(negedge clk_sys);
    check16({15'h0000, host_block_write_ready}, 16'h0000, "refused outside run");
    host_in_run = 1'b1;
    write_block(64);
    check16({15'h0000, host_block_write_ready}, 16'h0001, "resumed in run");
    wrap_up();
  end
endmodule
bind pcxpm_master pcxpm_master_chk pcxpm_master_chk_inst (.clk_sys(clk_sys), .rstn(rstn),
  .host_in_run(host_in_run), .host_block_write_ready(host_block_write_ready),
  .host_block_read_valid(host_block_read_valid), .host_block_read_ready(host_block_read_ready),
  .host_block_read_data(host_block_read_data), .ser_txd(ser_txd), .ser_rts(ser_rts));
